// ==== include/rcf_pkg.sv ====
// Constants, register map, event carrier and helpers for the reset-cause flag block
package rcf_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int FLAG_W = 16;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CAUSE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_WDT_STAT = 8'h0c;

  // ----------------------------------------------------------------
  // Cause register fields
  // ----------------------------------------------------------------
  localparam int BIT_TRAP = 15;
  localparam int BIT_ILLOP = 14;
  localparam int BIT_PIN = 7;
  localparam int BIT_SOFT = 6;
  localparam int BIT_WDTEN = 5;
  localparam int BIT_WDT_TIMEOUT = 4;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_IDLE = 2;
  localparam int BIT_BROWNOUT = 1;
  localparam int BIT_POR = 0;

  // Watchdog status register fields
  localparam int WDT_BIT_ACTIVE = 0;
  localparam int WDT_BIT_FUSE = 1;

  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  localparam logic [FLAG_W-1:0] CAUSE_IMPL_MASK = 16'hc0ff;
  localparam logic [FLAG_W-1:0] EVENT_MASK = 16'hc0df;
  localparam logic [FLAG_W-1:0] CAUSE_RESET = 16'h0003;
  localparam logic [FLAG_W-1:0] IRQ_RESET = 16'h0000;
  localparam logic [FLAG_W-1:0] POR_CLR_MASK = 16'hc0fe;
  localparam logic [FLAG_W-1:0] BROWNOUT_CLR_MASK = 16'hc05c;
  localparam logic [FLAG_W-1:0] SAVE_CLR_MASK = 16'h0010;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Event carrier: one-cycle pulses from reset sources and decoder
  // ----------------------------------------------------------------
  typedef struct packed {
    logic trapConflict;
    logic illegalOp;
    logic pinReset;
    logic softReset;
    logic wdtTimeout;
    logic saveSleep;
    logic saveIdle;
    logic brownoutRst;
    logic powerOnRst;
  } rcf_events_t;

  // Event pulses laid out as cause register bits
  function automatic logic [FLAG_W-1:0] event_set_vec(rcf_events_t e);
    logic [FLAG_W-1:0] v;
    v = '0;
    v[BIT_TRAP] = e.trapConflict;
    v[BIT_ILLOP] = e.illegalOp;
    v[BIT_PIN] = e.pinReset;
    v[BIT_SOFT] = e.softReset;
    v[BIT_WDT_TIMEOUT] = e.wdtTimeout;
    v[BIT_SLEEP] = e.saveSleep;
    v[BIT_IDLE] = e.saveIdle;
    v[BIT_BROWNOUT] = e.brownoutRst | e.powerOnRst;
    v[BIT_POR] = e.powerOnRst;
    return v;
  endfunction

  // Byte lane strobes widened to a flag mask
  function automatic logic [FLAG_W-1:0] lane_mask(logic [1:0] strb);
    return {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

endpackage

// ==== logic/rcf_flag_bank.sv ====
// Bank of flag flip-flops with software and hardware set and clear
`timescale 1ns/1ps
module rcf_flag_bank #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Software side
  input wire logic [15:0] swSet,
  input wire logic [15:0] swClr,
  // Hardware side
  input wire logic [15:0] hwSet,
  input wire logic [15:0] hwClr,
  // Flags
  output logic [15:0] flags
);

  // ----------------------------------------------------------------
  // One cell per bit; hardware set always wins
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 16; i++)
    begin : g_cell
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          flags[i] <= RESET_VAL[i];
        end
        else if (hwSet[i])
        begin
          flags[i] <= 1'b1;
        end
        else if (hwClr[i])
        begin
          flags[i] <= 1'b0;
        end
        else if (swSet[i])
        begin
          flags[i] <= 1'b1;
        end
        else if (swClr[i])
        begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// ==== logic/rcf_top.sv ====
// Reset-cause flag register block with AXI4-Lite slave and interrupt
`timescale 1ns/1ps
module rcf_top (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Reset source and power-save event pulses
  input wire rcf_pkg::rcf_events_t events,
  // Configuration fuse
  input wire logic wdtFuseEnable,
  // AXI4-Lite write address
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Block outputs
  output logic irq,
  output logic wdtEnable
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic is_reg(logic [7:0] addr, logic [7:0] off);
    return addr[7:2] == off[7:2];
  endfunction

  function automatic logic is_mapped(logic [7:0] addr);
    return is_reg(addr, rcf_pkg::OFF_CAUSE) | is_reg(addr, rcf_pkg::OFF_IRQ_STAT)
      | is_reg(addr, rcf_pkg::OFF_IRQ_MASK) | is_reg(addr, rcf_pkg::OFF_WDT_STAT);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic awready_reg;
  logic awready_next;
  logic wready_reg;
  logic wready_next;
  logic awHeld_reg;
  logic awHeld_next;
  logic wHeld_reg;
  logic wHeld_next;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic irq_reg;
  logic wdtEnable_reg;
  logic [15:0] irqMask_reg;

  logic awTake;
  logic wTake;
  logic doWrite;
  logic bDone;
  logic arTake;
  logic rDone;
  logic [15:0] laneMask;
  logic [15:0] wordBits;
  logic weCause;
  logic weIrqStat;
  logic weIrqMask;

  logic [15:0] causeFlags;
  logic [15:0] causeSwSet;
  logic [15:0] causeSwClr;
  logic [15:0] causeHwSet;
  logic [15:0] causeHwClr;
  logic [15:0] irqStat;
  logic [15:0] irqSwClr;
  logic [15:0] eventVec;
  logic [31:0] readWord;

  // ----------------------------------------------------------------
  // Write channel handshakes
  // ----------------------------------------------------------------
  assign awTake = awvalid & awready_reg;
  assign wTake = wvalid & wready_reg;
  assign doWrite = awHeld_reg & wHeld_reg & ~bvalid_reg;
  assign bDone = bvalid_reg & bready;

  always_comb
  begin
    awHeld_next = awHeld_reg | awTake;
    wHeld_next = wHeld_reg | wTake;
    bvalid_next = bvalid_reg & ~bDone;
    if (doWrite)
    begin
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bvalid_next = 1'b1;
    end
    awready_next = ~awHeld_next & ~bvalid_next;
    wready_next = ~wHeld_next & ~bvalid_next;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      bvalid_reg <= 1'b0;
    end
    else
    begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
      bvalid_reg <= bvalid_next;
    end
  end

  // Captured address and data
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end
    else
    begin
      if (awTake)
      begin
        awAddr_reg <= awaddr;
      end
      if (wTake)
      begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
    end
  end

  // Response code: unmapped writes are refused
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bresp_reg <= rcf_pkg::RESP_OKAY;
    end
    else if (doWrite)
    begin
      bresp_reg <= is_mapped(awAddr_reg) ? rcf_pkg::RESP_OKAY : rcf_pkg::RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  assign laneMask = rcf_pkg::lane_mask(wStrb_reg[1:0]);
  assign wordBits = wData_reg[15:0];
  assign weCause = doWrite & is_reg(awAddr_reg, rcf_pkg::OFF_CAUSE);
  assign weIrqStat = doWrite & is_reg(awAddr_reg, rcf_pkg::OFF_IRQ_STAT);
  assign weIrqMask = doWrite & is_reg(awAddr_reg, rcf_pkg::OFF_IRQ_MASK);

  // Ordinary write sets and clears flags; nothing here feeds any reset
  assign causeSwSet = {16{weCause}} & laneMask & wordBits
    & rcf_pkg::CAUSE_IMPL_MASK;
  assign causeSwClr = {16{weCause}} & laneMask & ~wordBits
    & rcf_pkg::CAUSE_IMPL_MASK;

  // ----------------------------------------------------------------
  // Hardware set and clear of the cause flags
  // ----------------------------------------------------------------
  assign eventVec = rcf_pkg::event_set_vec(events);

  // Sources set their own bit; power-on and brown-out set the brown-out bit
  assign causeHwSet = eventVec
    & rcf_pkg::EVENT_MASK;

  always_comb
  begin
    causeHwClr = '0;
    if (events.powerOnRst)
    begin
      causeHwClr = causeHwClr | rcf_pkg::POR_CLR_MASK;
    end
    if (events.brownoutRst)
    begin
      causeHwClr = causeHwClr | rcf_pkg::BROWNOUT_CLR_MASK;
    end
    if (events.saveSleep | events.saveIdle)
    begin
      causeHwClr = causeHwClr | rcf_pkg::SAVE_CLR_MASK;
    end
  end

  rcf_flag_bank #(
    .RESET_VAL(rcf_pkg::CAUSE_RESET)
  ) u_cause (
    .clk(clk),
    .arst_n(arst_n),
    .swSet(causeSwSet),
    .swClr(causeSwClr),
    .hwSet(causeHwSet),
    .hwClr(causeHwClr),
    .flags(causeFlags)
  );

  // ----------------------------------------------------------------
  // Interrupt status (write one to clear) and mask
  // ----------------------------------------------------------------
  assign irqSwClr = {16{weIrqStat}} & laneMask & wordBits & rcf_pkg::EVENT_MASK;

  rcf_flag_bank #(
    .RESET_VAL(rcf_pkg::IRQ_RESET)
  ) u_irq (
    .clk(clk),
    .arst_n(arst_n),
    .swSet(16'h0000),
    .swClr(irqSwClr),
    .hwSet(causeHwSet),
    .hwClr(16'h0000),
    .flags(irqStat)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqMask_reg <= rcf_pkg::IRQ_RESET;
    end
    else if (weIrqMask)
    begin
      irqMask_reg <= (irqMask_reg & ~laneMask) | (wordBits & laneMask & rcf_pkg::EVENT_MASK);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= |(irqStat & irqMask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Watchdog enable: fuse forces it on
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wdtEnable_reg <= 1'b0;
    end
    else
    begin
      wdtEnable_reg <= wdtFuseEnable | causeFlags[rcf_pkg::BIT_WDTEN];
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign arTake = arvalid & arready_reg;
  assign rDone = rvalid_reg & rready;

  always_comb
  begin
    readWord = 32'h0000_0000;
    if (is_reg(araddr, rcf_pkg::OFF_CAUSE))
    begin
      readWord[15:0] = causeFlags & rcf_pkg::CAUSE_IMPL_MASK;
    end
    else if (is_reg(araddr, rcf_pkg::OFF_IRQ_STAT))
    begin
      readWord[15:0] = irqStat;
    end
    else if (is_reg(araddr, rcf_pkg::OFF_IRQ_MASK))
    begin
      readWord[15:0] = irqMask_reg;
    end
    else if (is_reg(araddr, rcf_pkg::OFF_WDT_STAT))
    begin
      readWord[rcf_pkg::WDT_BIT_ACTIVE] = wdtEnable_reg;
      readWord[rcf_pkg::WDT_BIT_FUSE] = wdtFuseEnable;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
    else if (arTake)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
    end
    else if (rDone)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= rcf_pkg::RESP_OKAY;
    end
    else if (arTake)
    begin
      rdata_reg <= readWord;
      rresp_reg <= is_mapped(araddr) ? rcf_pkg::RESP_OKAY : rcf_pkg::RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign irq = irq_reg;
  assign wdtEnable = wdtEnable_reg;

endmodule

// ==== verification/rcf_asserts.sv ====
// Port-level checks for the reset-cause flag block
`timescale 1ns/1ps
module rcf_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Watchdog and interrupt
  input wire logic wdtFuseEnable,
  input wire logic irq,
  input wire logic wdtEnable
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_fuse; wdtFuseEnable |=> wdtEnable; endproperty
  a_fuse: assert property (p_fuse) else $error("watchdog off with fuse set");
  property p_rd_lat; arvalid && arready |=> rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat; awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer timing");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_done; rvalid && rready |=> !rvalid && arready; endproperty
  a_r_done: assert property (p_r_done) else $error("read not closed");
  property p_b_done; bvalid && bready |=> !bvalid && awready && wready; endproperty
  a_b_done: assert property (p_b_done) else $error("write not closed");
  property p_ar_block; rvalid |-> !arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("second read taken");
  property p_err_zero; rvalid && rresp == 2'h2 |-> rdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  c_err: cover property (bvalid && bresp == 2'h2);
  c_irq: cover property (irq);
  c_stall: cover property (rvalid && !rready);
endmodule
bind rcf_top rcf_asserts u_chk (.clk, .arst_n, .awvalid, .awready, .wvalid, .wready, .bresp,
  .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .wdtFuseEnable,
  .irq, .wdtEnable);

// ==== verification/rcf_tb_top.sv ====
// Self-checking bench for the reset-cause flag block
`timescale 1ns/1ps
module rcf_tb_top;
  logic clk, arst_n, wdtFuseEnable, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, wdtEnable;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  rcf_pkg::rcf_events_t events;
  logic [15:0] eCause, eStat, eMask;
  int numErrors, testsRun;
  localparam logic [7:0] ADDRS [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'hfc};
  localparam logic [31:0] FILL [2] = '{32'h0, 32'hffff};

  rcf_top dut (.clk, .arst_n, .events, .wdtFuseEnable, .awaddr, .awprot, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .irq, .wdtEnable);

  // ----
  // Helpers
  // ----
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim();
    if (numErrors == 0 && testsRun > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] evSet(rcf_pkg::rcf_events_t e);
    return {e.trapConflict, e.illegalOp, 6'h00, e.pinReset, e.softReset, 1'b0, e.wdtTimeout,
      e.saveSleep, e.saveIdle, e.brownoutRst | e.powerOnRst, e.powerOnRst};
  endfunction

  function automatic logic [15:0] evClr(rcf_pkg::rcf_events_t e);
    return (e.powerOnRst ? 16'hfffe : 16'h0000) | (e.brownoutRst ? 16'hc05c : 16'h0000)
      | (e.saveSleep | e.saveIdle ? 16'h0010 : 16'h0000);
  endfunction

  function automatic logic [31:0] regExp(logic [7:0] a);
    case (a)
      8'h00: return {16'h0, eCause};
      8'h04: return {16'h0, eStat};
      8'h08: return {16'h0, eMask};
      8'h0c: return {30'h0, wdtFuseEnable, wdtFuseEnable | eCause[5]};
      default: return 32'h0;
    endcase
  endfunction

  task automatic pulse(input rcf_pkg::rcf_events_t e);
    @(posedge clk);
    events <= e;
    @(posedge clk);
    events <= '0;
    eCause = (eCause & ~evClr(e)) | evSet(e);
    eStat = eStat | evSet(e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] ln;
    int lag;
    ln = {{8{s[1]}}, {8{s[0]}}};
    lag = $urandom_range(2);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    repeat (lag) @(posedge clk);
    bready <= 1'b1;
    do
      @(posedge clk);
    while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, a > 8'h0c ? 2'h2 : 2'h0});
    case (a)
      8'h00: eCause = (eCause & ~ln) | (d[15:0] & ln & 16'hc0ff);
      8'h04: eStat = eStat & ~(d[15:0] & ln);
      8'h08: eMask = (eMask & ~ln) | (d[15:0] & ln & 16'hc0df);
      default: ;
    endcase
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    int lag;
    lag = $urandom_range(2);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do
      @(posedge clk);
    while (!arready);
    arvalid <= 1'b0;
    repeat (lag) @(posedge clk);
    rready <= 1'b1;
    do
      @(posedge clk);
    while (!rvalid);
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, a > 8'h0c ? 2'h2 : 2'h0});
  endtask

  task automatic outs();
    repeat (2) @(posedge clk);
    chk({31'h0, wdtEnable}, {31'h0, wdtFuseEnable | eCause[5]});
    chk({31'h0, irq}, {31'h0, |(eStat & eMask)});
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    logic [7:0] a;
    {arst_n, events, wdtFuseEnable, awaddr, awprot, awvalid, wdata, wstrb} = '0;
    {wvalid, bready, araddr, arprot, arvalid, rready} = '0;
    numErrors = 0;
    testsRun = 0;
    eCause = 16'h0003;
    eStat = 16'h0;
    eMask = 16'h0;
    void'($urandom(32'hce03));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    foreach (ADDRS[i])
      rd(ADDRS[i], regExp(ADDRS[i]));
    for (int i = 0; i < 9; i++)
      foreach (FILL[j])
      begin
        wr(8'h00, FILL[j], 4'h3);
        pulse(rcf_pkg::rcf_events_t'(9'h001 << i));
        rd(8'h00, regExp(8'h00));
        outs();
      end
    wr(8'h00, 32'h0, 4'h3);
    wdtFuseEnable <= 1'b1;
    outs();
    wdtFuseEnable <= 1'b0;
    outs();
    wr(8'h00, 32'h20, 4'h1);
    outs();
    wr(8'h08, 32'hffff, 4'h3);
    pulse(rcf_pkg::rcf_events_t'(9'h100));
    outs();
    wr(8'h04, 32'hffff, 4'h3);
    outs();
    for (int n = 0; n < 60; n++)
    begin
      a = ADDRS[$urandom_range(5)];
      if (n == 30)
      begin
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        eCause = 16'h0003;
        eStat = 16'h0;
        eMask = 16'h0;
      end
      pulse(rcf_pkg::rcf_events_t'(9'($urandom & $urandom)));
      wdtFuseEnable <= 1'($urandom_range(1));
      wr(a, $urandom, 4'($urandom));
      rd(a, regExp(a));
      outs();
    end
    end_sim();
  end

  initial
  begin
    #2000000;
    numErrors++;
    end_sim();
  end
endmodule
